// ===== core/tmr_defs.svh
// Register offsets, field positions and reset values of the timer/event counter.
// Assumes inclusion by bare name from the core module and the bench.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define OFF_CTRL 12'h000
`define OFF_LOW 12'h004
`define OFF_HIGH 12'h008
`define OFF_PINSEL 12'h00C
`define OFF_TONE 12'h010
`define OFF_IRQ_STAT 12'h014
`define OFF_IRQ_MASK 12'h018
`define OFF_MAIN_IRQ 12'h01C
`define BIT_AUTO 3
`define BIT_ENABLE 3
`define BIT_PIN_OPT 0
`define BIT_IRQ_ZERO 0
`define BIT_MAIN_TE 2
`define RST_NIBBLE 4'h0
`define SRC_PIN 3'h7
`define SRC_OFF 3'h0
`endif

// ===== core/tmr_pkg.sv
// Types shared by the timer/event counter core.
// Assumes the constant header sits beside it.
package tmr_pkg;
  typedef struct packed {
    logic auto_reload_bit;
    logic [2:0] source_sel;
  } timer_control_t;
  typedef struct packed {
    logic port_debounce_disable;
    logic port_edge_select;
    logic event_input_pin;
    logic event_pin_debounced;
  } pin_in_t;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE
  } count_state_t;
endpackage : tmr_pkg

// ===== core/timer_event_counter.sv
// 8-bit down-counting timer/event counter with auto-reload behind an APB slave.
// Assumes synchronous prescaler taps and pin levels, and one 50 MHz system clock.
//
// Summary of operation
// - Eight-bit down counter; zero sets interrupt flag.
// - Interrupt output only while mask bit is one.
// - Event mode counts qualified pin edges.
// - Auto-reload bit resets to zero.
// - Counter runs only while enable bit set.
// - Low nibble write loads and starts counting.
// - High nibble held until next low write or auto-reload.
// - Setting auto-reload alone does not start.
// - Auto-reload: at zero flag, reload, continue.
// - Writing zero stops counter, clears auto-reload.
// - Low read returns live count; high read returns the nibble frozen at the last low read.
// - Three-bit select picks tap or pin.
// - Pin option picks debounce and edge.
// - Flag ignores mask; main register read clears.
`timescale 1ns/1ns
`include "tmr_defs.svh"
module timer_event_counter
  import tmr_pkg::*;
(
  // System.
  input wire logic clock_i,
  input wire logic reset_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Count sources.
  input wire logic [5:0] prescaler_taps_i,
  input wire pin_in_t pin_i,
  // Interrupts.
  output logic irq_o,
  output logic timer_irq_flag_o
);
  // ==========================================================================
  // Bus decode.
  // Every register answers in one access cycle, so the master never sees a wait state.
  // Unmapped offsets answer with an error and leave every register untouched.
  // Decoding is shared between the write strobe and the error flag.
  function automatic logic is_map(input logic [11:0] a);
    is_map = (a == `OFF_CTRL) || (a == `OFF_LOW) || (a == `OFF_HIGH) ||
             (a == `OFF_PINSEL) || (a == `OFF_TONE) || (a == `OFF_IRQ_STAT) ||
             (a == `OFF_IRQ_MASK) || (a == `OFF_MAIN_IRQ);
  endfunction : is_map

  logic acc;
  logic wr;
  logic rd;
  assign acc = psel_i && penable_i;
  assign wr = acc && pwrite_i && is_map(paddr_i);
  assign rd = acc && !pwrite_i;

  timer_control_t ctrl_ff;
  logic [3:0] high_hold_ff;
  logic [3:0] load_low_ff;
  logic pin_opt_ff;
  logic enable_ff;
  logic [2:0] tone_ff;
  logic stat_ff;
  logic mask_ff;
  logic [7:0] count_ff;
  logic [3:0] high_snap_ff;
  logic src_prev_ff;
  count_state_t state_ff;

  logic wr_low;
  logic [7:0] new_load;
  logic zero_load;
  assign wr_low = wr && (paddr_i == `OFF_LOW);
  assign new_load = {high_hold_ff, pwdata_i[3:0]};
  assign zero_load = wr_low && (new_load == 8'h00);

  // ==========================================================================
  // Control registers.
  // A zero load wins over a control write in the same cycle, because the stop
  // request must always leave the auto-reload bit cleared.
  // The high nibble is only staged here; it reaches the counter with the low write or an auto-reload.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_ff <= '0;
      high_hold_ff <= `RST_NIBBLE;
      load_low_ff <= `RST_NIBBLE;
      pin_opt_ff <= 1'b0;
      enable_ff <= 1'b0;
      tone_ff <= 3'h0;
      mask_ff <= 1'b0;
    end
    else
    begin
      if (zero_load)
        ctrl_ff.auto_reload_bit <= 1'b0;
      else if (wr && paddr_i == `OFF_CTRL)
        ctrl_ff <= timer_control_t'(pwdata_i[3:0]);
      if (wr && paddr_i == `OFF_HIGH)
        high_hold_ff <= pwdata_i[3:0];
      if (wr_low)
        load_low_ff <= pwdata_i[3:0];
      if (wr && paddr_i == `OFF_PINSEL)
        pin_opt_ff <= pwdata_i[`BIT_PIN_OPT];
      if (wr && paddr_i == `OFF_TONE)
      begin
        enable_ff <= pwdata_i[`BIT_ENABLE];
        tone_ff <= pwdata_i[2:0];
      end
      if (wr && paddr_i == `OFF_IRQ_MASK)
        mask_ff <= pwdata_i[`BIT_IRQ_ZERO];
    end
  end

  // ==========================================================================
  // Count source selection and edge qualification.
  // Taps and pin levels are taken as synchronous, so one flip-flop of history suffices.
  // Switching the source can produce one false edge; software should reload afterwards.
  // The edge detector resets low, matching the idle level of an inactive source.
  logic src_level;
  always_comb
  begin
    src_level = 1'b0;
    case (ctrl_ff.source_sel)
      3'h1: src_level = prescaler_taps_i[5];
      3'h2: src_level = prescaler_taps_i[4];
      3'h3: src_level = prescaler_taps_i[3];
      3'h4: src_level = prescaler_taps_i[2];
      3'h5: src_level = prescaler_taps_i[1];
      3'h6: src_level = prescaler_taps_i[0];
      `SRC_PIN:
      begin
        if (!pin_opt_ff)
          src_level = pin_i.event_pin_debounced;
        else
        begin
          src_level = pin_i.port_debounce_disable ? pin_i.event_input_pin
                                                  : pin_i.event_pin_debounced;
          if (!pin_i.port_edge_select)
            src_level = !src_level;
        end
      end
      default: src_level = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      src_prev_ff <= 1'b0;
    else
      src_prev_ff <= src_level;
  end

  logic tick;
  // Polarity is folded into the level so one rising detector serves both edges.
  assign tick = src_level && !src_prev_ff && enable_ff &&
                (ctrl_ff.source_sel != `SRC_OFF);

  // ==========================================================================
  // Counter state machine.
  // The flag is raised on the step from one, so an auto-reloading counter never
  // shows zero and no count period is lengthened by an extra cycle.
  // A low write always wins over a tick in the same cycle.
  // A stopped counter leaves its last value readable.
  logic hit_zero;
  assign hit_zero = (state_ff == ST_RUN) && tick && (count_ff == 8'h01) && !wr_low;

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      count_ff <= 8'h00;
      state_ff <= ST_IDLE;
    end
    else if (wr_low)
    begin
      count_ff <= new_load;
      state_ff <= zero_load ? ST_IDLE : ST_RUN;
    end
    else
    begin
      case (state_ff)
        ST_RUN:
        begin
          if (tick)
          begin
            if (hit_zero && ctrl_ff.auto_reload_bit)
              count_ff <= {high_hold_ff, load_low_ff};
            else
              count_ff <= count_ff - 8'h01;
            if (hit_zero && !ctrl_ff.auto_reload_bit)
              state_ff <= ST_DONE;
          end
        end
        ST_DONE: state_ff <= ST_DONE;
        ST_IDLE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt flag: set wins over both clears.
  // Losing a zero event to a simultaneous clear would drop timing information,
  // so the set takes priority and software sees the event on its next read.
  logic clr_stat;
  assign clr_stat = (rd && paddr_i == `OFF_MAIN_IRQ) ||
                    (wr && paddr_i == `OFF_IRQ_STAT && pwdata_i[`BIT_IRQ_ZERO]);
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      stat_ff <= 1'b0;
    else if (hit_zero)
      stat_ff <= 1'b1;
    else if (clr_stat)
      stat_ff <= 1'b0;
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_o <= 1'b0;
      timer_irq_flag_o <= 1'b0;
    end
    else
    begin
      irq_o <= stat_ff && mask_ff;
      timer_irq_flag_o <= stat_ff;
    end
  end

  // ==========================================================================
  // Read path; a low read freezes the high nibble so the pair is coherent.
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      high_snap_ff <= `RST_NIBBLE;
    else if (psel_i && !pwrite_i && !pready_o && paddr_i == `OFF_LOW)
      high_snap_ff <= count_ff[7:4];
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !pready_o;
      pslverr_o <= psel_i && !pready_o && !is_map(paddr_i);
      prdata_o <= 32'h0;
      if (psel_i && !pwrite_i && !pready_o)
      begin
        case (paddr_i)
          `OFF_CTRL: prdata_o[3:0] <= ctrl_ff;
          `OFF_LOW: prdata_o[3:0] <= count_ff[3:0];
          `OFF_HIGH: prdata_o[3:0] <= high_snap_ff;
          `OFF_PINSEL: prdata_o[0] <= pin_opt_ff;
          `OFF_TONE: prdata_o[3:0] <= {enable_ff, tone_ff};
          `OFF_IRQ_STAT: prdata_o[0] <= stat_ff;
          `OFF_IRQ_MASK: prdata_o[0] <= mask_ff;
          `OFF_MAIN_IRQ: prdata_o[`BIT_MAIN_TE] <= stat_ff;
          default: prdata_o <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks.
  // These guard the counter, flag and bus handshake behaviour; the bench covers the register map.
  chk_irq_masked: assert property (@(posedge clock_i) disable iff (reset_i)
    irq_o |-> $past(mask_ff) && $past(stat_ff))
    else $error("interrupt without mask");
  chk_zero_flag: assert property (@(posedge clock_i) disable iff (reset_i)
    hit_zero |=> stat_ff)
    else $error("zero did not set flag");
  chk_load_start: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_low |=> count_ff == $past(new_load))
    else $error("low write did not load");
  chk_zero_stop: assert property (@(posedge clock_i) disable iff (reset_i)
    zero_load |=> state_ff == ST_IDLE && !ctrl_ff.auto_reload_bit)
    else $error("zero load did not stop");
  chk_hold_zero: assert property (@(posedge clock_i) disable iff (reset_i)
    state_ff == ST_DONE && !wr_low |=> count_ff == 8'h00)
    else $error("count moved after stop");
  chk_no_enable: assert property (@(posedge clock_i) disable iff (reset_i)
    !enable_ff && !wr_low |=> $stable(count_ff))
    else $error("count moved while disabled");
  chk_reload_val: assert property (@(posedge clock_i) disable iff (reset_i)
    hit_zero && ctrl_ff.auto_reload_bit |=> count_ff == $past({high_hold_ff, load_low_ff}))
    else $error("reload value wrong");
  chk_step_one: assert property (@(posedge clock_i) disable iff (reset_i)
    state_ff == ST_RUN && tick && !wr_low && !hit_zero |=> count_ff == $past(count_ff) - 8'h01)
    else $error("step not one");
  cov_reload: cover property (@(posedge clock_i) hit_zero && ctrl_ff.auto_reload_bit);
  cov_pin_tick: cover property (@(posedge clock_i) tick && ctrl_ff.source_sel == `SRC_PIN);
  cov_irq: cover property (@(posedge clock_i) irq_o);
  cov_zero_load: cover property (@(posedge clock_i) zero_load);
  cov_flag_clear: cover property (@(posedge clock_i) clr_stat && stat_ff);

  chk_ready_pulse: assert property (@(posedge clock_i) disable iff (reset_i)
    pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");

  chk_err_ready: assert property (@(posedge clock_i) disable iff (reset_i)
    pslverr_o |-> pready_o)
    else $error("error without ready");

  chk_irq_follow: assert property (@(posedge clock_i) disable iff (reset_i)
    1'b1 |=> irq_o == $past(stat_ff && mask_ff))
    else $error("interrupt output does not follow flag and mask");

  chk_flag_copy: assert property (@(posedge clock_i) disable iff (reset_i)
    1'b1 |=> timer_irq_flag_o == $past(stat_ff))
    else $error("flag output does not follow flag");

  chk_flag_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    clr_stat && !hit_zero |=> !stat_ff)
    else $error("flag not cleared");

  chk_set_wins: assert property (@(posedge clock_i) disable iff (reset_i)
    hit_zero && clr_stat |=> stat_ff)
    else $error("clear beat a zero event");

  chk_idle_still: assert property (@(posedge clock_i) disable iff (reset_i)
    state_ff == ST_IDLE && !wr_low |=> $stable(count_ff))
    else $error("stopped counter moved");

  chk_done_stays: assert property (@(posedge clock_i) disable iff (reset_i)
    state_ff == ST_DONE && !wr_low |=> state_ff == ST_DONE)
    else $error("finished counter restarted without a load");

  chk_src_off: assert property (@(posedge clock_i) disable iff (reset_i)
    ctrl_ff.source_sel == `SRC_OFF |-> !tick)
    else $error("tick with no source selected");

  chk_high_held: assert property (@(posedge clock_i) disable iff (reset_i)
    wr && paddr_i == `OFF_HIGH |=> high_hold_ff == $past(pwdata_i[3:0]))
    else $error("high nibble not staged");
endmodule : timer_event_counter

// ===== dv/event_source_model.sv
// Far-side model: prescaler taps and the event input pin with its port settings.
// Assumes the bench calls pulse() from its clocked sequence.
`timescale 1ns/1ns
module event_source_model
  import tmr_pkg::*;
(
  // System.
  input wire logic clock_i,
  // Count sources.
  output logic [5:0] taps_o,
  output pin_in_t pin_o
);
  initial
  begin
    taps_o = 6'h00;
    pin_o = '0;
  end
  // =========================================
  // Pulse
  // Debounced and raw pin move together, so one pulse is one edge of either polarity.
  task automatic pulse(input int i);
    @(posedge clock_i);
    if (i < 6) taps_o[i] <= 1'b1;
    else {pin_o.event_input_pin, pin_o.event_pin_debounced} <= 2'h3;
    repeat (3) @(posedge clock_i);
    taps_o <= 6'h00;
    {pin_o.event_input_pin, pin_o.event_pin_debounced} <= 2'h0;
    repeat (3) @(posedge clock_i);
  endtask : pulse
endmodule : event_source_model

// ===== dv/timer_event_counter_tb.sv
// Self-checking bench of the timer/event counter against a behavioural model.
// Assumes the design answers APB in one access cycle, offsets as in tmr_defs.svh.
`timescale 1ns/1ns
`include "tmr_defs.svh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module timer_event_counter_tb
  import tmr_pkg::*;
;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, h;
  logic pready, pslverr, irq, flag_o;
  logic [5:0] taps;
  pin_in_t pin;
  int errors = 0, n_checks = 0, cnt = 0, rl = 0, au = 0, en = 0, fl = 0, mk = 0;
  logic [31:0] rs = 32'd95;
  timer_event_counter u_dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .prescaler_taps_i(taps), .pin_i(pin), .irq_o(irq), .timer_irq_flag_o(flag_o));
  event_source_model u_src (.clock_i(clock_i), .taps_o(taps), .pin_o(pin));
  initial
  begin
    forever #10 clock_i = ~clock_i;
  end
  // =========================================
  // Helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (k == 50)
    begin
      errors++;
      end_sim();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Low is read first so the high nibble comes from the same snapshot.
  task automatic rd_cnt();
    apb(1'b0, `OFF_LOW, 32'h0);
    h = q;
    apb(1'b0, `OFF_HIGH, 32'h0);
    `CHK("count", cnt[7:0], {q[3:0], h[3:0]})
    `CHK("flag", fl[0], flag_o)
    `CHK("irq", fl[0] & mk[0], irq)
  endtask : rd_cnt
  task automatic load(input int v);
    apb(1'b1, `OFF_HIGH, 32'(v >> 4));
    apb(1'b1, `OFF_LOW, 32'(v & 15));
    rl = v;
    cnt = v;
    if (v == 0) au = 0;
  endtask : load
  task automatic tick(input int i);
    u_src.pulse(i);
    if (en != 0 && cnt != 0)
    begin
      if (cnt == 1)
      begin
        fl = 1;
        cnt = (au != 0) ? rl : 0;
      end
      else cnt--;
    end
    rd_cnt();
  endtask : tick
  // =========================================
  // Sequence
  initial
  begin
    int s, v;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    for (s = 0; s < 8; s++)
    begin
      apb(1'b0, 12'(s * 4), 32'h0);
      `CHK("reset value", 32'h0, q)
    end
    apb(1'b0, 12'h040, 32'h0);
    `CHK("unmapped", 1'b1, pslverr)
    load(3);
    tick(5);
    apb(1'b1, `OFF_TONE, 32'h8);
    en = 1;
    for (s = 1; s < 7; s++)
    begin
      v = rnd() % 4 + 1;
      apb(1'b1, `OFF_CTRL, 32'(s));
      load(v);
      repeat (v + 1) tick(6 - s);
      apb(1'b1, `OFF_IRQ_STAT, 32'h1);
      fl = 0;
    end
    apb(1'b1, `OFF_IRQ_MASK, 32'h1);
    mk = 1;
    apb(1'b1, `OFF_CTRL, 32'hF);
    au = 1;
    apb(1'b1, `OFF_HIGH, 32'h1);
    rd_cnt();
    apb(1'b1, `OFF_LOW, 32'h2);
    rl = 18;
    cnt = 18;
    repeat (19) tick(6);
    apb(1'b0, `OFF_MAIN_IRQ, 32'h0);
    `CHK("main irq", 1'b1, q[2])
    fl = 0;
    rd_cnt();
    load(0);
    apb(1'b0, `OFF_CTRL, 32'h0);
    `CHK("auto cleared", 4'h7, q[3:0])
    apb(1'b1, `OFF_PINSEL, 32'h1);
    u_src.pin_o.port_debounce_disable <= 1'b1;
    load(2);
    repeat (2) tick(6);
    apb(1'b1, `OFF_TONE, 32'h0);
    en = 0;
    load(5);
    tick(6);
    load(255);
    apb(1'b1, `OFF_TONE, 32'h8);
    en = 1;
    repeat (3) tick(6);
    `CHK("event count", 8'h03, ~{q[3:0], h[3:0]})
    end_sim();
  end
  initial
  begin
    repeat (100000) @(posedge clock_i);
    errors++;
    end_sim();
  end
endmodule : timer_event_counter_tb
